// ===== pdlf_predecode.sv
`timescale 1ns/1ps
`include "pdlf_regs.svh"
module pdlf_predecode (
  input  wire logic           i_clock,
  input  wire logic           i_srst,
  input  wire logic           i_line_valid,
  input  wire logic [127:0]   i_line,
  input  wire logic [3:0]     i_insn_start,
  input  wire logic [3:0]     i_insn_len,
  input  wire logic           i_has_prefix,
  input  wire logic           i_fixed_sixteen_bit_immediate,
  input  wire logic           i_rex_only,
  input  wire logic           i_has_sib,
  input  wire logic           i_disp8,
  input  wire logic [3:0]     i_modrm_ofs,
  input  wire logic           i_newer_core,
  input  wire logic           i_pair_valid,
  input  wire pdlf_pkg::pdlf_first_t  i_first,
  input  wire pdlf_pkg::pdlf_opnd_t   i_opnd,
  input  wire pdlf_pkg::pdlf_branch_t i_branch,
  input  wire logic           i_same_reg,
  output logic                o_line_ready,
  output logic                o_out_valid,
  output logic [3:0]          o_out_len,
  output logic                o_stall,
  output logic [3:0]          o_penalty,
  output logic                o_fused,
  output logic [2:0]          o_ports
);
  import pdlf_pkg::*;

  typedef enum logic [1:0] {PDLF_IDLE, PDLF_SLOW} pdlf_state_t;

  pdlf_state_t state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [3:0]  len_ff, pen_ff;
  logic        valid_ff, stall_ff, fused_ff;
  logic [2:0]  ports_ff;
  logic        fusible;
  logic [2:0]  pair_ports;

  // scan the line for 0x66 / 0x67; rex (4x) bytes are not matched
  logic [15:0] pfx_hit;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_scan
      assign pfx_hit[g] = (i_line[g*8 +: 8] == `PDLF_PFX_OPSIZE) ||
                          (i_line[g*8 +: 8] == `PDLF_PFX_ADSIZE); // [RULE_04]
    end
  endgenerate

  // fast path takes the given length; length 0 is clamped to 1
  wire [3:0] fast_len = (i_insn_len == 4'h0) ? 4'h1 : i_insn_len; // [RULE_01] [RULE_02]
  wire       line_has_pfx = |pfx_hit && i_has_prefix;
  // fixed sixteen_bit_immediate or rex-only sizing never changes length
  wire       length_changing_prefix = line_has_pfx && !i_fixed_sixteen_bit_immediate && !i_rex_only; // [RULE_05] [RULE_06]
  wire       crosses = ({1'b0, i_insn_start} + {1'b0, fast_len}) >
                       `PDLF_LINE_BYTES;
  wire       split_sib = i_has_sib && (i_modrm_ofs == 4'hF); // [RULE_07]
  wire       off13_d8  = i_disp8 &&
                         (i_insn_start == `PDLF_OFS_DISP8); // [RULE_07]
  // plain sixteen_bit_immediate forms without sib or disp8 stay single
  wire       dbl = length_changing_prefix && crosses && (split_sib || off13_d8); // [RULE_09]
  // F7 at 14: modrm in next line, length unknown
  wire       false_lcp = line_has_pfx &&
                         (i_line[i_insn_start*8 +: 8] == `PDLF_OP_GRP3) &&
                         (i_insn_start == `PDLF_OFS_GRP3); // [RULE_10]
  wire       slow = length_changing_prefix || false_lcp; // [RULE_03]
  wire [3:0] slow_total = dbl ? `PDLF_DOUBLE_CYC : `PDLF_SLOW_CYC; // [RULE_08]
  wire       take = (state_ff == PDLF_IDLE) && i_line_valid;
  wire       done = (state_ff == PDLF_SLOW) && (cnt_ff == 4'h1);

  pdlf_fuse_slot u_fuse (
    .i_first      (i_first),
    .i_opnd       (i_opnd),
    .i_branch     (i_branch),
    .i_same_reg   (i_same_reg),
    .i_newer_core (i_newer_core),
    .o_fusible    (fusible),
    .o_ports      (pair_ports)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      PDLF_IDLE: begin
        // counts remaining cycles after the first one
        if (take && slow) begin
          nxt_state = PDLF_SLOW;
          nxt_cnt   = slow_total - 4'h1; // [RULE_03] [RULE_08]
        end
      end
      PDLF_SLOW: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (done) begin
          nxt_state = PDLF_IDLE;
        end
      end
      default: nxt_state = PDLF_IDLE;
    endcase
  end

  // line is held by fetch until ready; slow line accepted on first cycle
  wire ready_now = (nxt_state == PDLF_IDLE); // [RULE_19] [RULE_20]

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= PDLF_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      valid_ff <= 1'b0;
      len_ff   <= 4'h0;
      pen_ff   <= 4'h0;
      stall_ff <= 1'b0;
      fused_ff <= 1'b0;
      ports_ff <= 3'h0;
    end else begin
      valid_ff <= (take && !slow) || done;
      stall_ff <= (nxt_state == PDLF_SLOW); // [RULE_19]
      if (take) begin
        len_ff   <= fast_len;
        pen_ff   <= slow ? slow_total : 4'h1;
        // one pair per line result keeps to one fused pair a cycle
        fused_ff <= i_pair_valid && fusible; // [RULE_18]
        ports_ff <= pair_ports; // [RULE_14] [RULE_15]
      end
    end
  end

  // ready registered: low through reset, shows idle-next from the first clock after reset release
  logic ready_ff;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= ready_now && !(take && slow);
    end
  end

  assign o_line_ready = ready_ff;
  assign o_out_valid  = valid_ff;
  assign o_out_len    = len_ff;
  assign o_stall      = stall_ff;
  assign o_penalty    = pen_ff;
  assign o_fused      = fused_ff;
  assign o_ports      = ports_ff;
endmodule : pdlf_predecode

// ===== pdlf_regs.svh
// Functional notes
// [RULE_01] instruction lengths from one to fifteen bytes
// [RULE_02] fast path assumes no length changing prefix
// [RULE_03] prefixed line takes six cycles, not one
// [RULE_04] prefixes 0x66 and 0x67 change length
// [RULE_05] fixed sixteen bit immediate never stalls; false_lcp (prefixed F7 at offset 14) still stalls six cycles
// [RULE_06] rex prefix in 64-bit mode never stalls; false_lcp (prefixed F7 at offset 14) ignores i_rex_only and stalls six cycles
// [RULE_07] modrm/sib split or offset 13 disp8 stalls twice
// [RULE_08] double stall costs eleven cycles total
// [RULE_09] no sib, no disp8: single stall anywhere
// [RULE_10] prefixed F7 at offset 14 stalls fully
// [RULE_11] mem-imm cmp with jge unfused; reg-imm jae fused
// [RULE_12] test x,x flags equal cmp x,0
// [RULE_13] newer core fuses add, sub, and, inc, dec too
// [RULE_14] fused pair goes to port 5 only
// [RULE_15] plain alu goes to port 0, 1 or 5
// [RULE_16] pair is cmp/test then conditional branch
// [RULE_17] mem-imm cmp/test never fuses
// [RULE_18] at most one fused pair per cycle
// [RULE_19] hold line and back-pressure during stall
// [RULE_20] fetch keeps line stable under back-pressure
`ifndef PDLF_REGS_SVH
`define PDLF_REGS_SVH
`define PDLF_MAX_LEN      4'hF
`define PDLF_LINE_BYTES   5'h10
`define PDLF_SLOW_CYC     4'h6
`define PDLF_DOUBLE_CYC   4'hB
`define PDLF_PFX_OPSIZE   8'h66
`define PDLF_PFX_ADSIZE   8'h67
`define PDLF_OP_GRP3      8'hF7
`define PDLF_OFS_DISP8    4'hD
`define PDLF_OFS_GRP3     4'hE
`define PDLF_PORT0        3'h1
`define PDLF_PORT1        3'h2
`define PDLF_PORT5        3'h4
`endif

// ===== pdlf_pkg.sv
package pdlf_pkg;
  typedef enum logic [2:0] {
    PDLF_FK_NONE, PDLF_FK_CMP, PDLF_FK_TEST, PDLF_FK_ADD,
    PDLF_FK_SUB, PDLF_FK_AND, PDLF_FK_INCDEC
  } pdlf_first_t;
  typedef enum logic [1:0] {
    PDLF_OPND_RR, PDLF_OPND_RI, PDLF_OPND_RM, PDLF_OPND_MI
  } pdlf_opnd_t;
  // branch condition class by flags examined
  typedef enum logic [2:0] {
    PDLF_BR_NONE, PDLF_BR_OVF, PDLF_BR_CARRY, PDLF_BR_ZERO,
    PDLF_BR_CZ, PDLF_BR_SIGNPAR, PDLF_BR_SIGNED
  } pdlf_branch_t;
endpackage : pdlf_pkg

// ===== pdlf_fuse_slot.sv
`timescale 1ns/1ps
`include "pdlf_regs.svh"
module pdlf_fuse_slot (
  input  wire pdlf_pkg::pdlf_first_t  i_first,
  input  wire pdlf_pkg::pdlf_opnd_t   i_opnd,
  input  wire pdlf_pkg::pdlf_branch_t i_branch,
  input  wire logic                   i_same_reg,
  input  wire logic                   i_newer_core,
  output logic                        o_fusible,
  output logic [2:0]                  o_ports
);
  import pdlf_pkg::*;

  // test x,x sets flags as cmp x,0: treat that cmp as test
  wire  cmp_zero_as_test = (i_first == PDLF_FK_CMP) && i_same_reg; // [RULE_12]
  wire  is_test = (i_first == PDLF_FK_TEST) || cmp_zero_as_test;
  wire  is_cmp  = (i_first == PDLF_FK_CMP) && !cmp_zero_as_test;
  wire  is_br   = (i_branch != PDLF_BR_NONE);
  wire  mem_imm = (i_opnd == PDLF_OPND_MI); // [RULE_17]
  wire  cmp_ok  = is_cmp && (i_branch != PDLF_BR_OVF) &&
                  (i_branch != PDLF_BR_SIGNPAR); // [RULE_11]
  wire  and_ok  = i_newer_core && (i_first == PDLF_FK_AND);
  wire  addsub_ok = i_newer_core && ((i_first == PDLF_FK_ADD) ||
                    (i_first == PDLF_FK_SUB)) && cmp_ok == 1'b0 &&
                    (i_branch != PDLF_BR_OVF) &&
                    (i_branch != PDLF_BR_SIGNPAR); // [RULE_13]
  wire  incdec_ok = i_newer_core && (i_first == PDLF_FK_INCDEC) &&
                    ((i_branch == PDLF_BR_ZERO) ||
                     (i_branch == PDLF_BR_SIGNED)); // [RULE_13]
  wire  kind_ok = is_test || cmp_ok || and_ok || addsub_ok || incdec_ok;
  assign o_fusible = is_br && !mem_imm && kind_ok; // [RULE_16]
  assign o_ports   = o_fusible ? `PDLF_PORT5 :
                     (`PDLF_PORT0 | `PDLF_PORT1 | `PDLF_PORT5); // [RULE_14] [RULE_15]
endmodule : pdlf_fuse_slot

// ===== pdlf_predecode_sva.sv
`timescale 1ns/1ps
module pdlf_predecode_sva (
  input wire logic                 i_clock,
  input wire logic                 i_srst,
  input wire logic                 i_line_valid,
  input wire logic                 i_has_prefix,
  input wire logic                 i_fixed_sixteen_bit_immediate,
  input wire logic                 i_rex_only,
  input wire pdlf_pkg::pdlf_opnd_t i_opnd,
  input wire logic                 o_line_ready,
  input wire logic                 o_out_valid,
  input wire logic                 o_stall,
  input wire logic [3:0]           o_penalty,
  input wire logic                 o_fused,
  input wire logic [2:0]           o_ports
);
  import pdlf_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  wire take = i_line_valid && o_line_ready;
  wire exempt = !i_has_prefix || i_fixed_sixteen_bit_immediate || i_rex_only;
  a_ready_low: assert property
    ($rose(o_stall) |-> (!o_line_ready)[*4]) else $error("ready in stall");
  a_take_answer: assert property
    (take |=> o_out_valid || o_stall) else $error("take unanswered");
  a_fast_one: assert property
    (take ##1 !o_stall |-> o_out_valid && o_penalty == 4'h1)
    else $error("fast line wrong");
  a_slow_six: assert property
    ($rose(o_stall) && o_penalty == 4'h6 |-> ##5 o_out_valid)
    else $error("slow line not six");
  a_double_eleven: assert property
    ($rose(o_stall) && o_penalty == 4'hB |-> ##10 o_out_valid)
    else $error("double stall not eleven");
  a_exempt_fast: assert property
    (take && exempt |=> !o_stall) else $error("exempt line stalled");
  a_fused_port: assert property
    (o_fused |-> o_ports == 3'h4) else $error("fused off port5");
  a_memimm_unfused: assert property
    (take && i_opnd == PDLF_OPND_MI |=> !o_fused) else $error("mem-imm fused");
  c_fast: cover property (take ##1 o_out_valid);
  c_slow: cover property ($rose(o_stall) && o_penalty == 4'h6);
  c_fused: cover property (o_out_valid && o_fused);
endmodule : pdlf_predecode_sva
bind pdlf_predecode pdlf_predecode_sva u_sva (.i_clock, .i_srst,
  .i_line_valid, .i_has_prefix, .i_fixed_sixteen_bit_immediate, .i_rex_only, .i_opnd,
  .o_line_ready, .o_out_valid, .o_stall, .o_penalty, .o_fused, .o_ports);

// ===== pdlf_fetch_model.sv
`timescale 1ns/1ps
module pdlf_fetch_model (
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic         i_send,
  input  wire logic [127:0] i_data,
  input  wire logic         i_ready,
  output logic              o_valid,
  output logic [127:0]      o_line
);
  logic         valid_ff;
  logic [127:0] held_ff;
  assign o_valid = valid_ff;
  // idle line shows inverse, stale bytes never look valid
  assign o_line = valid_ff ? held_ff : ~held_ff;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      valid_ff <= 1'b0;
    end else if (i_send) begin
      valid_ff <= 1'b1;
      held_ff <= i_data;
    end else if (i_ready) begin
      valid_ff <= 1'b0; // line held until taken
    end
  end
endmodule : pdlf_fetch_model

// ===== pdlf_predecode_test.sv
`timescale 1ns/1ps
module pdlf_predecode_test;
  import pdlf_pkg::*;
  logic i_clock, i_srst, send, valid, ready, ov, stall, fused, newer, pv;
  logic same, pfx, sixteen_bit_immediate, rex, sib, d8;
  logic [3:0] start, ilen, mofs, olen, pen;
  logic [2:0] ports;
  logic [127:0] data, line;
  pdlf_first_t first;
  pdlf_opnd_t opnd;
  pdlf_branch_t br;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  pdlf_fetch_model fetch (.i_clock, .i_srst, .i_send(send), .i_data(data),
    .i_ready(ready), .o_valid(valid), .o_line(line));
  pdlf_predecode uut (.i_clock, .i_srst, .i_line_valid(valid), .i_line(line),
    .i_insn_start(start), .i_insn_len(ilen), .i_has_prefix(pfx),
    .i_fixed_sixteen_bit_immediate(sixteen_bit_immediate), .i_rex_only(rex), .i_has_sib(sib), .i_disp8(d8),
    .i_modrm_ofs(mofs), .i_newer_core(newer), .i_pair_valid(pv),
    .i_first(first), .i_opnd(opnd), .i_branch(br), .i_same_reg(same),
    .o_line_ready(ready), .o_out_valid(ov), .o_out_len(olen),
    .o_stall(stall), .o_penalty(pen), .o_fused(fused), .o_ports(ports));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [127:0] d, input logic [3:0] p,
                     input logic f);
    int n;
    data = d;
    send = 1'b1;
    @(negedge i_clock);
    send = 1'b0;
    while (!(valid && ready)) @(negedge i_clock);
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
      if (n == 1) chk({7'h0, stall}, {7'h0, p != 4'h1});
      if (n == 1) chk({7'h0, ready}, {7'h0, p == 4'h1});
    end while (!ov && n < 20);
    chk(8'(n), 8'(p));
    chk(8'(pen), 8'(p));
    chk(8'(olen), 8'(ilen));
    chk({7'h0, fused}, {7'h0, f});
    if (pv) chk({5'h0, ports}, f ? 8'h04 : 8'h07);
  endtask : run
  task automatic pair(input pdlf_first_t f, input pdlf_opnd_t o,
                      input pdlf_branch_t b, input logic e);
    first = f;
    opnd = o;
    br = b;
    run(128'h0, 4'h1, e);
  endtask : pair
  task automatic t_length;
    run(128'h0, 4'h1, 1'b0);
    ilen = 4'h5;
    pfx = 1'b1;
    run(128'h66, 4'h6, 1'b0);
    run(128'h67 << 40, 4'h6, 1'b0);
    sixteen_bit_immediate = 1'b1;
    run(128'h66, 4'h1, 1'b0);
    sixteen_bit_immediate = 1'b0;
    rex = 1'b1;
    run(128'h66, 4'h1, 1'b0);
    rex = 1'b0;
  endtask : t_length
  task automatic t_double;
    start = 4'hD;
    d8 = 1'b1;
    run(128'h66 << 104, 4'hB, 1'b0);
    d8 = 1'b0;
    run(128'h66 << 104, 4'h6, 1'b0);
    start = 4'hE;
    run(128'hF766 << 104, 4'h6, 1'b0);
    start = 4'hC;
    sib = 1'b1;
    mofs = 4'hF;
    run(128'h66 << 96, 4'hB, 1'b0);
    sib = 1'b0;
    pfx = 1'b0;
  endtask : t_double
  task automatic t_fuse;
    pv = 1'b1;
    pair(PDLF_FK_CMP, PDLF_OPND_RI, PDLF_BR_CARRY, 1'b1);
    pair(PDLF_FK_CMP, PDLF_OPND_MI, PDLF_BR_SIGNED, 1'b0);
    pair(PDLF_FK_TEST, PDLF_OPND_MI, PDLF_BR_ZERO, 1'b0);
    for (int b = 1; b < 7; b++) begin
      pair(PDLF_FK_TEST, PDLF_OPND_RR, pdlf_branch_t'(b), 1'b1);
    end
    pair(PDLF_FK_CMP, PDLF_OPND_RI, PDLF_BR_SIGNPAR, 1'b0);
    same = 1'b1;
    pair(PDLF_FK_CMP, PDLF_OPND_RI, PDLF_BR_SIGNPAR, 1'b1);
    pair(PDLF_FK_ADD, PDLF_OPND_RR, PDLF_BR_ZERO, 1'b0);
    newer = 1'b1;
    pair(PDLF_FK_ADD, PDLF_OPND_RR, PDLF_BR_ZERO, 1'b1);
    pair(PDLF_FK_AND, PDLF_OPND_RR, PDLF_BR_OVF, 1'b1);
    pair(PDLF_FK_INCDEC, PDLF_OPND_RR, PDLF_BR_CARRY, 1'b0);
  endtask : t_fuse
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    {i_srst, send, newer, pv, same, pfx, sixteen_bit_immediate, rex, sib, d8} = 10'h200;
    {start, ilen, mofs} = 12'h0F0;
    data = 128'h0;
    first = PDLF_FK_NONE;
    opnd = PDLF_OPND_RR;
    br = PDLF_BR_NONE;
    repeat (16) @(negedge i_clock);
    i_srst = 1'b0;
    t_length();
    t_double();
    t_fuse();
    final_report();
  end
endmodule : pdlf_predecode_test
